/* File: verilog/pafo_pkg.sv */
// Package for the port alternate-function override mux.
// Assumes one system clock; all pins and fuses arrive as plain ports.
package pafo_pkg;
  // Pin indices inside the port B low nibble
  localparam int unsigned PB_CAP   = 0;      // Capture / clock out pin
  localparam int unsigned PB_TIMER1_COMPARE_A_OUT  = 1;      // Timer 1 compare A pin
  localparam int unsigned PB_SS    = 2;      // Slave select / compare B pin
  localparam int unsigned PB_MOSI  = 3;      // Data out / timer 2 pin
  localparam int unsigned PB_NUM   = 4;      // Port B pins handled
  // Pin indices inside the port C upper group
  localparam int unsigned PC_SDA   = 0;      // Port C bit 4
  localparam int unsigned PC_SCL   = 1;      // Port C bit 5
  localparam int unsigned PC_RST   = 2;      // Port C bit 6
  localparam int unsigned PC_NUM   = 3;      // Port C pins handled
  localparam int unsigned PC_BASE  = 4;      // Port C bit of index 0
  // Pin-change source numbering
  localparam int unsigned PCI_PC_BASE = 12;  // Source of port C bit 4
  localparam int unsigned PCI_NUM     = 15;  // Sources 0..14 carried
  // Reset values of the registered pad controls
  localparam logic [PB_NUM-1:0] PB_RST_VAL = 4'h0;
  localparam logic [PC_NUM-1:0] PC_RST_VAL = 3'h0;

  // Per-port pad control bundle
  typedef struct packed {
    logic [PB_NUM-1:0] oe;     // Output driver enable
    logic [PB_NUM-1:0] val;    // Driven value
    logic [PB_NUM-1:0] pu;     // Pull-up enable
    logic [PB_NUM-1:0] die;    // Digital input enable
  } pafo_pb_pad_t;

  typedef struct packed {
    logic [PC_NUM-1:0] oe;
    logic [PC_NUM-1:0] val;
    logic [PC_NUM-1:0] pu;
    logic [PC_NUM-1:0] die;
  } pafo_pc_pad_t;

  // Synchroniser and registered output state
  typedef struct packed {
    logic [PB_NUM-1:0]  pb_s1;     // Port B first stage
    logic [PB_NUM-1:0]  pb_s2;     // Port B second stage
    logic [PC_NUM-1:0]  pc_s1;     // Port C first stage
    logic [PC_NUM-1:0]  pc_s2;     // Port C second stage
    pafo_pb_pad_t       pb_pad;    // Port B pad controls
    pafo_pc_pad_t       pc_pad;    // Port C pad controls
    logic               xtal7_die; // Bit 7 input enable override
    logic               xtal7_input_enable_override_enable;
    logic               mosi_in;   // Slave data in
    logic               ss_n_in;   // Slave select
    logic               cap_in;    // Timer 1 capture
    logic               miso_mst;  // Master data in
    logic               scl_in;
    logic               sda_in;
    logic [PCI_NUM-1:0] pci_src;   // Pin-change sources
    logic [2:0]         c6_rd;     // Direction/out/in reads of C6
  } pafo_state_t;
endpackage : pafo_pkg

/* File: verilog/pafo_mux.sv */
// Alternate-function override mux for port B bits 3..0 and port C bits 6..4.
// Assumes fuses are static, peripherals run on ref_clk_in, and the pad ring
// resolves the pad from oe/val/pu; pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
module pafo_mux
  import pafo_pkg::*;
(
  input  wire logic               ref_clk_in,               // 50 MHz system clock
  input  wire logic               reset_in,                 // Async reset, active high
  input  wire logic               clk_en_in,                // Freezes state when low
  input  wire logic               sleep_in,                 // Device asleep
  input  wire logic               global_pullup_disable_in, // Pull-ups off globally
  input  wire logic               spi_enable_bit_in,        // SPI enabled
  input  wire logic               spi_master_select_in,     // SPI is master
  input  wire logic               spi_master_data_in,       // Master data out
  input  wire logic               spi_slave_data_in,        // Master-in pin level
  input  wire logic [PB_NUM-1:0]  pb_dir_in,                // Port B direction bits
  input  wire logic [PB_NUM-1:0]  pb_out_in,                // Port B output bits
  input  wire logic [PB_NUM-1:0]  pb_pin_in,                // Port B pad levels
  input  wire logic               timer2_compare_out_in,    // Timer 2 compare level
  input  wire logic               timer2_compare_en_in,     // Timer 2 owns pin
  input  wire logic               timer1_compare_a_out_in,  // Timer 1 compare A
  input  wire logic               timer1_compare_a_en_in,   // Timer 1 A owns pin
  input  wire logic               timer1_compare_b_out_in,  // Timer 1 compare B
  input  wire logic               timer1_compare_b_en_in,   // Timer 1 B owns pin
  input  wire logic               clock_output_fuse_in,     // Clock-out fuse programmed
  input  wire logic               divided_clock_in,         // Divided system clock
  input  wire logic               internal_rc_selected_in,  // Clock select: internal RC
  input  wire logic               external_clock_selected_in, // Clock select: external
  input  wire logic               async_timer_enable_in,    // Async timer on
  input  wire logic               reset_disable_fuse_in,    // Reset pin is I/O
  input  wire logic               two_wire_enable_in,       // Two-wire interface on
  input  wire logic               scl_drive_low_in,         // Two-wire pulls clock low
  input  wire logic               sda_drive_low_in,         // Two-wire pulls data low
  input  wire logic [PC_NUM-1:0]  pc_dir_in,                // Port C bits 6..4 direction
  input  wire logic [PC_NUM-1:0]  pc_out_in,                // Port C bits 6..4 output
  input  wire logic [PC_NUM-1:0]  pc_pin_in,                // Port C bits 6..4 pads
  input  wire logic [PB_NUM-1:0]  pb_pci_mask_in,           // Pin-change masks 3..0
  input  wire logic [PC_NUM-1:0]  pc_pci_mask_in,           // Pin-change masks 14..12
  input  wire logic               pin_change_group_enable_in,  // Port B group
  input  wire logic               pin_change_group1_enable_in, // Port C group
  output logic      [PB_NUM-1:0]  pb_oe_out,                // Port B driver enable
  output logic      [PB_NUM-1:0]  pb_val_out,               // Port B driven value
  output logic      [PB_NUM-1:0]  pb_pu_out,                // Port B pull-up
  output logic      [PB_NUM-1:0]  pb_die_out,               // Port B input enable
  output logic      [PC_NUM-1:0]  pc_oe_out,                // Port C driver enable
  output logic      [PC_NUM-1:0]  pc_val_out,               // Port C driven value
  output logic      [PC_NUM-1:0]  pc_pu_out,                // Port C pull-up
  output logic      [PC_NUM-1:0]  pc_die_out,               // Port C input enable
  output logic                    xtal2_die_out,            // Bit 7 input enable value
  output logic                    xtal2_input_enable_override_enable_out,          // Bit 7 override enable
  output logic                    spi_slave_data_out,       // Slave data in path
  output logic                    spi_master_data_out,      // Master data in path
  output logic                    spi_slave_select_n_out,   // Slave select, active low
  output logic                    timer1_capture_out,       // Capture input
  output logic                    scl_in_out,               // Two-wire clock in
  output logic                    sda_in_out,               // Two-wire data in
  output logic      [PCI_NUM-1:0] pin_change_src_out,       // Sources 0..14
  output logic      [2:0]         c6_read_out               // C6 dir/out/in reads
);

  pafo_state_t st_r;    // Registered state, all but the clock-out flop
  pafo_state_t st_nxt;  // Next state
  logic        divided_clock_out_r;  // Divided clock for bit 0; unreset so it runs on in reset

  // Shared override terms
  logic spi_on;      // SPI enabled
  logic spi_mst;     // SPI as master
  logic spi_slv;     // SPI as slave
  logic rc_or_ext;   // Oscillator decode term
  logic rst_pin;     // C6 serves as reset
  logic [PB_NUM-1:0] pb_direction_override_enable;  // Port B direction override enable
  logic [PB_NUM-1:0] pb_direction_override_value;  // Port B direction override value
  logic [PB_NUM-1:0] pb_port_value_override_enable;  // Port B value override enable
  logic [PB_NUM-1:0] pb_port_value_override_value;  // Port B value override value
  logic [PB_NUM-1:0] pb_force; // Pin forced to input by SPI
  logic [PC_NUM-1:0] pc_direction_override_enable;
  logic [PC_NUM-1:0] pc_direction_override_value;
  logic [PC_NUM-1:0] pc_port_value_override_enable;
  logic [PC_NUM-1:0] pc_port_value_override_value;
  logic [PC_NUM-1:0] pc_input_enable_override_enable;
  logic [PC_NUM-1:0] pc_input_enable_override_value;
  logic [PB_NUM-1:0] pb_pci_on;  // Pin-change armed, port B
  logic [PC_NUM-1:0] pc_pci_on;  // Pin-change armed, port C

  // Override terms, one place so both ports agree
  always_comb begin
    spi_on    = spi_enable_bit_in;
    spi_mst   = spi_on & spi_master_select_in;
    spi_slv   = spi_on & ~spi_master_select_in;
    rc_or_ext = internal_rc_selected_in | external_clock_selected_in;
    rst_pin   = ~reset_disable_fuse_in;
    pb_pci_on = pb_pci_mask_in & {PB_NUM{pin_change_group_enable_in}};
    pc_pci_on = pc_pci_mask_in & {PC_NUM{pin_change_group1_enable_in}};
    // Slave forces data-in and select to input; master keeps register
    pb_force           = '0;
    pb_force[PB_MOSI]  = spi_slv;
    pb_force[PB_SS]    = spi_slv;
    pb_direction_override_enable            = pb_force;
    pb_direction_override_value            = '0;
    pb_port_value_override_enable            = '0;
    pb_port_value_override_value            = '0;
    // Compare outputs replace the value only; direction stays the register's
    pb_port_value_override_enable[PB_MOSI]   = spi_mst | timer2_compare_en_in;
    pb_port_value_override_value[PB_MOSI]   = (spi_mst & spi_master_data_in) |
                         (timer2_compare_en_in & timer2_compare_out_in);
    pb_port_value_override_enable[PB_SS]     = timer1_compare_b_en_in;
    pb_port_value_override_value[PB_SS]     = timer1_compare_b_out_in;
    pb_port_value_override_enable[PB_TIMER1_COMPARE_A_OUT]   = timer1_compare_a_en_in;
    pb_port_value_override_value[PB_TIMER1_COMPARE_A_OUT]   = timer1_compare_a_out_in;
    // Clock fuse owns bit 0 entirely
    pb_direction_override_enable[PB_CAP]    = clock_output_fuse_in;
    pb_direction_override_value[PB_CAP]    = clock_output_fuse_in;
    pb_port_value_override_enable[PB_CAP]    = clock_output_fuse_in;
    pb_port_value_override_value[PB_CAP]    = divided_clock_in;
    // Port C: reset pin and two-wire pins
    pc_direction_override_enable            = '0;
    pc_direction_override_value            = '0;
    pc_port_value_override_enable            = '0;
    pc_port_value_override_value            = '0;
    pc_direction_override_enable[PC_RST]    = rst_pin;
    pc_direction_override_enable[PC_SCL]    = two_wire_enable_in;
    pc_direction_override_value[PC_SCL]    = scl_drive_low_in;              // Open drain: drive only low
    pc_port_value_override_enable[PC_SCL]    = two_wire_enable_in;
    pc_direction_override_enable[PC_SDA]    = two_wire_enable_in;
    pc_direction_override_value[PC_SDA]    = sda_drive_low_in;
    pc_port_value_override_enable[PC_SDA]    = two_wire_enable_in;
    pc_input_enable_override_enable           = pc_pci_on;
    pc_input_enable_override_value           = pc_pci_on;
    pc_input_enable_override_enable[PC_RST]   = rst_pin | pc_pci_on[PC_RST];
    pc_input_enable_override_value[PC_RST]   = rst_pin | pc_pci_on[PC_RST];
  end

  // Next-state: synchronisers, pad controls and peripheral inputs
  always_comb begin
    st_nxt       = st_r;
    st_nxt.pb_s1 = pb_pin_in;
    st_nxt.pb_s2 = st_r.pb_s1;
    st_nxt.pc_s1 = pc_pin_in;
    st_nxt.pc_s2 = st_r.pc_s1;
    for (int i = 0; i < PB_NUM; i++) begin
      st_nxt.pb_pad.oe[i]  = pb_direction_override_enable[i] ? pb_direction_override_value[i] : pb_dir_in[i];
      st_nxt.pb_pad.val[i] = pb_port_value_override_enable[i] ? pb_port_value_override_value[i] : pb_out_in[i];
      // Pull-up follows the output bit even when SPI forces input
      st_nxt.pb_pad.pu[i]  = ~st_nxt.pb_pad.oe[i] & pb_out_in[i] &
                             ~global_pullup_disable_in;
      // Pin-change keeps input alive in sleep
      st_nxt.pb_pad.die[i] = pb_pci_on[i] | ~sleep_in;
    end
    for (int j = 0; j < PC_NUM; j++) begin
      st_nxt.pc_pad.oe[j]  = pc_direction_override_enable[j] ? pc_direction_override_value[j] : pc_dir_in[j];
      st_nxt.pc_pad.val[j] = pc_port_value_override_enable[j] ? pc_port_value_override_value[j] : pc_out_in[j];
      st_nxt.pc_pad.pu[j]  = ~st_nxt.pc_pad.oe[j] & pc_out_in[j] &
                             ~global_pullup_disable_in & ~pc_direction_override_enable[j];
      st_nxt.pc_pad.die[j] = pc_input_enable_override_enable[j] ? pc_input_enable_override_value[j] : ~sleep_in;
    end
    // Oscillator pin 7 override terms
    st_nxt.xtal7_die   = rc_or_ext & async_timer_enable_in;
    st_nxt.xtal7_input_enable_override_enable = (internal_rc_selected_in & external_clock_selected_in) |
                         async_timer_enable_in;
    // Peripheral input paths from the second synchroniser stage; master data in comes from spi_slave_data_in
    st_nxt.mosi_in  = st_r.pb_s2[PB_MOSI];
    st_nxt.miso_mst = spi_mst & spi_slave_data_in;
    st_nxt.ss_n_in  = spi_slv ? st_r.pb_s2[PB_SS] : 1'b1;
    st_nxt.cap_in   = st_r.pb_s2[PB_CAP];
    st_nxt.scl_in   = two_wire_enable_in & st_r.pc_s2[PC_SCL];
    st_nxt.sda_in   = two_wire_enable_in & st_r.pc_s2[PC_SDA];
    st_nxt.pci_src  = '0;
    st_nxt.pci_src[PB_NUM-1:0] = st_r.pb_s2;
    st_nxt.pci_src[PCI_PC_BASE +: PC_NUM] = st_r.pc_s2;
    // Reset pin reads as zero
    st_nxt.c6_rd = rst_pin ? 3'h0 :
                   {pc_dir_in[PC_RST], pc_out_in[PC_RST], st_r.pc_s2[PC_RST]};
  end

  // State register; the bit 0 clock-out path lives in its own flop below
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r        <= '0;
      // Select idles high, so the peripheral sees no false select after reset
      st_r.ss_n_in <= 1'b1;
    end else if (clk_en_in) begin
      st_r        <= st_nxt;
    end
  end

  // Clock-out flop has no reset: the divided clock must stay on bit 0 in reset.
  // Trade-off: one flop outside the state struct, still frozen by clk_en_in.
  always_ff @(posedge ref_clk_in) begin
    if (clk_en_in) begin
      divided_clock_out_r <= divided_clock_in;
    end
  end

  // Outputs straight from the state flops; bit 0 from the clock-out flop when the clock fuse is programmed
  always_comb begin
    pb_oe_out              = st_r.pb_pad.oe;
    pb_val_out             = st_r.pb_pad.val;
    // Fuse is static, so switching the source here cannot glitch the pad
    if (clock_output_fuse_in) begin
      pb_oe_out[PB_CAP]    = 1'b1;
      pb_val_out[PB_CAP]   = divided_clock_out_r;
    end
    pb_pu_out              = st_r.pb_pad.pu;
    pb_die_out             = st_r.pb_pad.die;
    pc_oe_out              = st_r.pc_pad.oe;
    pc_val_out             = st_r.pc_pad.val;
    pc_pu_out              = st_r.pc_pad.pu;
    pc_die_out             = st_r.pc_pad.die;
    xtal2_die_out          = st_r.xtal7_die;
    xtal2_input_enable_override_enable_out        = st_r.xtal7_input_enable_override_enable;
    spi_slave_data_out     = st_r.mosi_in;
    spi_master_data_out    = st_r.miso_mst;
    spi_slave_select_n_out = st_r.ss_n_in;
    timer1_capture_out     = st_r.cap_in;
    scl_in_out             = st_r.scl_in;
    sda_in_out             = st_r.sda_in;
    pin_change_src_out     = st_r.pci_src;
    c6_read_out            = st_r.c6_rd;
  end

endmodule : pafo_mux
`default_nettype wire

/* File: sim/pafo_asserts.sv */
// Checker: port-level properties of the alternate-function override mux.
// Bound into pafo_mux; outputs follow inputs one enabled clock later.
`timescale 1ns/100ps
`default_nettype none
module pafo_asserts
  import pafo_pkg::*;
(
  input wire logic              ref_clk_in, reset_in, clk_en_in, // Clock, reset, run
  input wire logic              spi_enable_bit_in, spi_master_select_in, // SPI mode
  input wire logic              global_pullup_disable_in, clock_output_fuse_in, // Globals
  input wire logic              divided_clock_in, reset_disable_fuse_in, // Clock out, C6
  input wire logic              timer1_compare_a_en_in, timer1_compare_a_out_in, // Timer 1 A
  input wire logic              internal_rc_selected_in, external_clock_selected_in, // Osc
  input wire logic              async_timer_enable_in, xtal2_die_out, // Bit 7 terms
  input wire logic [PB_NUM-1:0] pb_dir_in, pb_out_in, pb_oe_out, pb_val_out, pb_pu_out, // B
  input wire logic [2:0]        c6_read_out // C6 reads
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Decodes for the checks, slave_w shared by three; kept as nets so $past sees a plain signal
  wire logic slave_w = spi_enable_bit_in & ~spi_master_select_in;
  wire logic master_w = spi_enable_bit_in & spi_master_select_in;
  wire logic xtal_w = (internal_rc_selected_in | external_clock_selected_in) & async_timer_enable_in;

  a_slave_data_in: assert property (clk_en_in && slave_w |=> !pb_oe_out[3])
    else $error("data pin driven in slave mode");
  a_master_data_dir: assert property (clk_en_in && master_w
    |=> pb_oe_out[3] == $past(pb_dir_in[3])) else $error("data pin direction wrong");
  a_slave_select_in: assert property (clk_en_in && slave_w |=> !pb_oe_out[2])
    else $error("select pin driven in slave mode");
  a_forced_pullup: assert property (clk_en_in && slave_w && !global_pullup_disable_in
    |=> pb_pu_out[3:2] == $past(pb_out_in[3:2])) else $error("forced input lost pull-up");
  a_clock_out_pin: assert property (clk_en_in && clock_output_fuse_in
    |=> pb_oe_out[0] && pb_val_out[0] == $past(divided_clock_in)) else $error("no clock out");
  a_t1a_drive: assert property (clk_en_in && timer1_compare_a_en_in && pb_dir_in[1]
    |=> pb_oe_out[1] && pb_val_out[1] == $past(timer1_compare_a_out_in))
    else $error("compare A not driven");
  a_c6_reads_zero: assert property (clk_en_in && !reset_disable_fuse_in
    |=> c6_read_out == 3'h0) else $error("reset pin reads not zero");
  a_xtal_die: assert property (clk_en_in |=> xtal2_die_out == $past(xtal_w))
    else $error("bit 7 input enable wrong");
endmodule : pafo_asserts
bind pafo_mux pafo_asserts pafo_asserts_inst (.ref_clk_in, .reset_in, .clk_en_in,
  .spi_enable_bit_in, .spi_master_select_in, .global_pullup_disable_in, .clock_output_fuse_in,
  .divided_clock_in, .reset_disable_fuse_in, .timer1_compare_a_en_in, .timer1_compare_a_out_in,
  .internal_rc_selected_in, .external_clock_selected_in, .async_timer_enable_in, .xtal2_die_out,
  .pb_dir_in, .pb_out_in, .pb_oe_out, .pb_val_out, .pb_pu_out, .c6_read_out);
`default_nettype wire

/* File: sim/pafo_pad_model.sv */
// Pad model: resolves each pin from the mux pad controls and outside drivers.
// Assumes outside drivers are only on while the pad driver is off.
`timescale 1ns/100ps
`default_nettype none
module pafo_pad_model #(
  parameter int W = 4                  // Pins modelled
) (
  input wire logic         ref_clk_in, // Clock for the floating pattern
  input wire logic [W-1:0] oe_in,      // Driver enable
  input wire logic [W-1:0] val_in,     // Driven value
  input wire logic [W-1:0] pu_in,      // Pull-up
  input wire logic [W-1:0] ext_en_in,  // Outside driver on
  input wire logic [W-1:0] ext_val_in, // Outside level
  output logic     [W-1:0] pin_out     // Level seen by the mux
);
  // A floating pin flips each cycle, so a stale level cannot pass a check
  logic [W-1:0] float_r = '0;
  always_ff @(posedge ref_clk_in) begin
    float_r <= ~float_r;
  end
  // Own driver wins, then outside driver, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_out[i] = oe_in[i] ? val_in[i] : ext_en_in[i] ? ext_val_in[i] : pu_in[i] | float_r[i];
    end
  end
endmodule : pafo_pad_model
`default_nettype wire

/* File: sim/pafo_mux_bench.sv */
// Self-checking bench for pafo_mux, with pad models on both ports.
// Assumes pin paths settle within five enabled clocks.
`timescale 1ns/100ps
`default_nettype none
module pafo_mux_bench;
  import pafo_pkg::*;
  logic ref_clk_in, reset_in, clk_en_in, sleep_in, global_pullup_disable_in; // Globals
  logic spi_enable_bit_in, spi_master_select_in, spi_master_data_in, spi_slave_data_in; // SPI
  logic timer2_compare_out_in, timer2_compare_en_in, timer1_compare_a_out_in; // Timers
  logic timer1_compare_a_en_in, timer1_compare_b_out_in, timer1_compare_b_en_in;
  logic clock_output_fuse_in, divided_clock_in, internal_rc_selected_in; // Clocking
  logic external_clock_selected_in, async_timer_enable_in, reset_disable_fuse_in;
  logic two_wire_enable_in, scl_drive_low_in, sda_drive_low_in; // Two-wire
  logic pin_change_group_enable_in, pin_change_group1_enable_in; // Pin-change groups
  logic [PB_NUM-1:0] pb_dir_in, pb_out_in, pb_pin_in, pb_pci_mask_in, pb_ext_en, pb_ext_val;
  logic [PB_NUM-1:0] pb_oe_out, pb_val_out, pb_pu_out, pb_die_out; // Port B pads
  logic [PC_NUM-1:0] pc_dir_in, pc_out_in, pc_pin_in, pc_pci_mask_in, pc_ext_en, pc_ext_val;
  logic [PC_NUM-1:0] pc_oe_out, pc_val_out, pc_pu_out, pc_die_out; // Port C pads
  logic xtal2_die_out, xtal2_input_enable_override_enable_out, spi_slave_data_out, spi_master_data_out;
  logic spi_slave_select_n_out, timer1_capture_out, scl_in_out, sda_in_out;
  logic [PCI_NUM-1:0] pin_change_src_out; // Pin-change sources
  logic [2:0]         c6_read_out;        // C6 reads
  int                 errors, n_checks;   // Counters

  pafo_mux pafo_mux_inst (.ref_clk_in, .reset_in, .clk_en_in, .sleep_in,
    .global_pullup_disable_in, .spi_enable_bit_in, .spi_master_select_in, .spi_master_data_in,
    .spi_slave_data_in, .pb_dir_in, .pb_out_in, .pb_pin_in, .timer2_compare_out_in,
    .timer2_compare_en_in, .timer1_compare_a_out_in, .timer1_compare_a_en_in,
    .timer1_compare_b_out_in, .timer1_compare_b_en_in, .clock_output_fuse_in, .divided_clock_in,
    .internal_rc_selected_in, .external_clock_selected_in, .async_timer_enable_in,
    .reset_disable_fuse_in, .two_wire_enable_in, .scl_drive_low_in, .sda_drive_low_in,
    .pc_dir_in, .pc_out_in, .pc_pin_in, .pb_pci_mask_in, .pc_pci_mask_in,
    .pin_change_group_enable_in, .pin_change_group1_enable_in, .pb_oe_out, .pb_val_out,
    .pb_pu_out, .pb_die_out, .pc_oe_out, .pc_val_out, .pc_pu_out, .pc_die_out, .xtal2_die_out,
    .xtal2_input_enable_override_enable_out, .spi_slave_data_out, .spi_master_data_out, .spi_slave_select_n_out,
    .timer1_capture_out, .scl_in_out, .sda_in_out, .pin_change_src_out, .c6_read_out);
  pafo_pad_model #(.W(PB_NUM)) pafo_pad_model_inst (.ref_clk_in, .oe_in(pb_oe_out),
    .val_in(pb_val_out), .pu_in(pb_pu_out), .ext_en_in(pb_ext_en), .ext_val_in(pb_ext_val),
    .pin_out(pb_pin_in));
  pafo_pad_model #(.W(PC_NUM)) pafo_pad_model_c_inst (.ref_clk_in, .oe_in(pc_oe_out),
    .val_in(pc_val_out), .pu_in(pc_pu_out), .ext_en_in(pc_ext_en), .ext_val_in(pc_ext_val),
    .pin_out(pc_pin_in));

  // 50 MHz clock
  always #10 ref_clk_in = ~ref_clk_in;

  // Compare and count; pin paths need two sync stages plus the output flop
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic settle;
    repeat (5) @(posedge ref_clk_in);
    #1;
  endtask : settle
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: the sequence needs under 140 clocks
  initial begin
    #(20 * 5000);
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {sleep_in, global_pullup_disable_in, spi_enable_bit_in, spi_master_select_in,
     spi_master_data_in, spi_slave_data_in, timer2_compare_out_in, timer2_compare_en_in,
     timer1_compare_a_out_in, timer1_compare_a_en_in, timer1_compare_b_out_in,
     timer1_compare_b_en_in, clock_output_fuse_in, divided_clock_in, internal_rc_selected_in,
     external_clock_selected_in, async_timer_enable_in, reset_disable_fuse_in,
     two_wire_enable_in, scl_drive_low_in, sda_drive_low_in, pin_change_group_enable_in,
     pin_change_group1_enable_in, pb_dir_in, pb_out_in, pb_pci_mask_in, pb_ext_en, pb_ext_val,
     pc_dir_in, pc_out_in, pc_pci_mask_in, pc_ext_en, pc_ext_val} = '0;
    ref_clk_in = 1'b0;
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    errors = 0;
    n_checks = 0;
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    // Slave: both SPI pins forced in, pull-ups still from the output bits
    spi_enable_bit_in <= 1'b1;
    pb_dir_in <= 4'hf;
    pb_out_in <= 4'hc;
    pb_ext_en <= 4'hc;
    pb_ext_val <= 4'h8;
    settle();
    chk("spi_oe", pb_oe_out[3:2], 2'h0);
    chk("spi_pu", pb_pu_out[3:2], 2'h3);
    chk("ss_n", spi_slave_select_n_out, 1'b0);
    chk("slave_in", spi_slave_data_out, 1'b1);
    // Master: directions from the register, data pin carries master output
    @(posedge ref_clk_in);
    spi_master_select_in <= 1'b1;
    pb_dir_in <= 4'h8;
    pb_ext_en <= 4'h0;
    spi_master_data_in <= 1'b1;
    spi_slave_data_in <= 1'b1;
    settle();
    chk("mst_oe", pb_oe_out[3:2], 2'h2);
    chk("mst_val", pb_val_out[3], 1'b1);
    chk("mst_in", spi_master_data_out, 1'b1);
    chk("ss_n_mst", spi_slave_select_n_out, 1'b1);
    // Timer outputs drive only pins set to output
    @(posedge ref_clk_in);
    {spi_enable_bit_in, spi_master_select_in, pb_out_in} <= 6'h00;
    {timer2_compare_en_in, timer1_compare_a_en_in, timer1_compare_b_en_in} <= 3'h7;
    {timer2_compare_out_in, timer1_compare_a_out_in, timer1_compare_b_out_in} <= 3'h7;
    pb_dir_in <= 4'he;
    settle();
    chk("tmr_oe", pb_oe_out[3:1], 3'h7);
    chk("tmr_val", pb_val_out[3:1], 3'h7);
    @(posedge ref_clk_in);
    pb_dir_in <= 4'h0;
    settle();
    chk("tmr_off", pb_oe_out[3:1], 3'h0);
    // Divided clock out overrides bit 0, also while reset is held
    @(posedge ref_clk_in);
    clock_output_fuse_in <= 1'b1;
    divided_clock_in <= 1'b1;
    settle();
    chk("divided_clock_out", {pb_oe_out[0], pb_val_out[0]}, 2'h3);
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    settle();
    chk("divided_clock_out_rst", {pb_oe_out[0], pb_val_out[0]}, 2'h3);
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    clock_output_fuse_in <= 1'b0;
    // Pin-change numbering and capture input, two patterns
    pb_ext_en <= 4'hf;
    pb_ext_val <= 4'ha;
    pc_ext_en <= 3'h7;
    pc_ext_val <= 3'h5;
    settle();
    chk("pci_a", pin_change_src_out, 15'h500a);
    chk("cap_a", timer1_capture_out, 1'b0);
    @(posedge ref_clk_in);
    pb_ext_val <= 4'h5;
    pc_ext_val <= 3'h2;
    settle();
    chk("pci_b", pin_change_src_out, 15'h2005);
    chk("cap_b", timer1_capture_out, 1'b1);
    // Two-wire: open drain on C5/C4, inputs follow the pins
    @(posedge ref_clk_in);
    two_wire_enable_in <= 1'b1;
    scl_drive_low_in <= 1'b1;
    pc_ext_en <= 3'h1;
    pc_ext_val <= 3'h1;
    settle();
    chk("twi_oe", {pc_oe_out[1:0], pc_val_out[1:0]}, 4'h8);
    chk("twi_in", {scl_in_out, sda_in_out}, 2'h1);
    // Reset pin: I/O only with the fuse programmed, reads zero otherwise
    @(posedge ref_clk_in);
    {two_wire_enable_in, pc_ext_en} <= 4'h0;
    pc_dir_in <= 3'h4;
    pc_out_in <= 3'h4;
    settle();
    chk("c6_rd", {c6_read_out, pc_oe_out[2]}, 4'h0);
    @(posedge ref_clk_in);
    reset_disable_fuse_in <= 1'b1;
    settle();
    chk("c6_io", {c6_read_out[2:1], pc_oe_out[2]}, 3'h7);
    // I/O pin as input: pull-up from the output bit, input reads the pad
    @(posedge ref_clk_in);
    pc_dir_in <= 3'h0;
    settle();
    chk("c6_pu", {c6_read_out, pc_pu_out}, 6'h1c);
    // Bit 7 input enable over all oscillator decodes
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_in);
      {internal_rc_selected_in, external_clock_selected_in, async_timer_enable_in} <= 3'(i);
      settle();
      chk("xtal_die", xtal2_die_out, (i[2] | i[1]) & i[0]);
      chk("xtal_input_enable_override_enable", xtal2_input_enable_override_enable_out, (i[2] & i[1]) | i[0]);
    end
    // Sleep keeps only the armed pin-change input alive
    @(posedge ref_clk_in);
    {sleep_in, pin_change_group_enable_in, pb_pci_mask_in} <= 6'h31;
    {pin_change_group1_enable_in, pc_pci_mask_in} <= 4'ha;
    settle();
    chk("sleep_die", pb_die_out, 4'h1);
    chk("sleep_die_c", pc_die_out, 3'h2);
    end_of_test();
  end
endmodule : pafo_mux_bench
`default_nettype wire
